// *** include/slt_params.svh ***
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SLT_OFS_RX_CS 4'h0
`define SLT_OFS_RX_BUF 4'h2
`define SLT_OFS_TX_CS 4'h4
`define SLT_OFS_TX_BUF 4'h6
`define SLT_OFS_RATE 4'h8
`define SLT_OFS_IRQ_STS 4'hA
`define SLT_OFS_IRQ_MASK 4'hC

// ************************************************************
// field positions
// ************************************************************
`define SLT_TX_RDY_BIT 7
`define SLT_TX_IE_BIT 6
`define SLT_LOOP_BIT 2
`define SLT_BRK_BIT 0
`define SLT_RX_DONE_BIT 7
`define SLT_RX_IE_BIT 6
`define SLT_MDM_IE_BIT 5
`define SLT_MDM_CHG_BIT 15
`define SLT_CARRIER_BIT 14
`define SLT_CTS_BIT 13
`define SLT_SEC_BIT 12
`define SLT_RING_BIT 10
`define SLT_EV_RX 0
`define SLT_EV_TX 1
`define SLT_EV_MDM 2

// ************************************************************
// reset values and timing
// ************************************************************
`define SLT_RATE_RST 16'h3535
`define SLT_IRQ_MASK_RST 3'h0
`define SLT_VECTOR_DEF 8'h30
`define SLT_VECTOR_STEP 8'h04
`define SLT_LEVEL_DEF 3'h4
`define SLT_SUB_LAST 4'hF
`define SLT_SUB_MID 4'h7
`define SLT_TX_BIT_LAST 4'h9
`define SLT_RX_BIT_LAST 4'h7

`endif

// *** include/slt_pkg.sv ***
package slt_pkg;

    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [1:0] {
        SLT_TX_IDLE = 2'b01,
        SLT_TX_SEND = 2'b10
    } slt_tx_state_t;

    typedef enum logic [3:0] {
        SLT_RX_IDLE = 4'b0001,
        SLT_RX_START = 4'b0010,
        SLT_RX_DATA = 4'b0100,
        SLT_RX_STOP = 4'b1000
    } slt_rx_state_t;

endpackage : slt_pkg

// *** design/slt_top.sv ***
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "slt_params.svh"

module slt_top
    import slt_pkg::*;
#(
    parameter logic [7:0] VECTOR_BASE = `SLT_VECTOR_DEF,
    parameter logic [2:0] REQUEST_LEVEL = `SLT_LEVEL_DEF
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic serial_in,
    output logic serial_out,
    input wire logic carrier_sense,
    input wire logic clear_to_send_in,
    input wire logic secondary_receive_in,
    input wire logic ring_indicate_in,
    input wire logic bus_grant,
    output logic bus_request,
    output logic [2:0] bus_request_level,
    output logic [7:0] vector,
    output logic vector_valid,
    output logic irq
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic tx_irq_enable;
        logic loopback_test;
        logic brk;
        logic [7:0] hold;
        logic hold_full;
        slt_tx_state_t tx_state;
        logic [9:0] tx_shift;
        logic [3:0] tx_bitn;
        logic [3:0] tx_sub;
        logic [7:0] tx_cnt;
        logic ser_out;
        logic s1;
        logic s2;
        logic s3;
        logic rx_lvl;
        logic [3:0] m1;
        logic [3:0] m2;
        logic [3:0] m3;
        logic [3:0] mdm;
        slt_rx_state_t rx_state;
        logic [3:0] rx_sub;
        logic [3:0] rx_bitn;
        logic [7:0] rx_sh;
        logic [7:0] rx_buf;
        logic [7:0] rx_cnt;
        logic rx_char_complete;
        logic rx_irq_enable;
        logic modem_irq_enable;
        logic modem_chg;
        logic [7:0] tx_div;
        logic [7:0] rx_div;
        logic [2:0] sts;
        logic [2:0] mask;
        logic irq;
        logic rx_pend;
        logic tx_pend;
        logic bus_req;
        logic [2:0] level;
        logic [7:0] vec;
        logic vec_valid;
        logic [15:0] rdata;
    } slt_state_t;

    slt_state_t st_reg;
    slt_state_t st_next;

    // returns {tick, next count}; tick once per div+1 cycles
    function automatic logic [8:0] slt_tick_step(
        input logic [7:0] cnt,
        input logic [7:0] div
    );
        logic [8:0] r;
        if (cnt >= div) begin
            r = {1'b1, 8'h00};
        end else begin
            r = {1'b0, cnt + 8'h01};
        end
        return r;
    endfunction : slt_tick_step

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic tx_tick;
        logic rx_own_tick;
        logic rx_tick;
        logic rx_in;
        logic wr_txcs;
        logic wr_rxcs;
        logic ev_tx;
        logic ev_rx;
        logic ev_mdm;
        logic tx_ie_rise;
        logic rx_ie_rise;
        logic mdm_ie_rise;
        logic [15:0] rd_val;
        st_next = st_reg;
        tx_tick = 1'b0;
        rx_own_tick = 1'b0;
        rx_tick = 1'b0;
        rx_in = 1'b1;
        wr_txcs = reg_wr && (reg_addr == `SLT_OFS_TX_CS);
        wr_rxcs = reg_wr && (reg_addr == `SLT_OFS_RX_CS);
        ev_tx = 1'b0;
        ev_rx = 1'b0;
        ev_mdm = 1'b0;
        tx_ie_rise = 1'b0;
        rx_ie_rise = 1'b0;
        mdm_ie_rise = 1'b0;
        rd_val = 16'h0000;
        st_next.vec_valid = 1'b0;
        st_next.level = REQUEST_LEVEL;

        {tx_tick, st_next.tx_cnt} = slt_tick_step(st_reg.tx_cnt,
                                                  st_reg.tx_div);
        {rx_own_tick, st_next.rx_cnt} = slt_tick_step(st_reg.rx_cnt,
                                                      st_reg.rx_div);
        // loopback clocks the receiver from the transmitter rate
        rx_tick = st_reg.loopback_test ? tx_tick : rx_own_tick;

        // ************************************************************
        // pin synchronisers
        // ************************************************************
        st_next.s1 = serial_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.rx_lvl = st_reg.s3;
        end
        st_next.m1 = {carrier_sense, clear_to_send_in,
                      secondary_receive_in, ring_indicate_in};
        st_next.m2 = st_reg.m1;
        st_next.m3 = st_reg.m2;
        for (int i = 0; i < 4; i++) begin
            if (st_reg.m2[i] == st_reg.m3[i]) begin
                st_next.mdm[i] = st_reg.m3[i];
            end
        end
        ev_mdm = |(st_next.mdm ^ st_reg.mdm);

        // ************************************************************
        // register writes and read side effects
        // ************************************************************
        if (wr_txcs) begin
            tx_ie_rise = reg_wdata[`SLT_TX_IE_BIT] &&
                         !st_reg.tx_irq_enable;
            st_next.tx_irq_enable = reg_wdata[`SLT_TX_IE_BIT];
            st_next.loopback_test = reg_wdata[`SLT_LOOP_BIT];
            st_next.brk = reg_wdata[`SLT_BRK_BIT];
        end
        if (wr_rxcs) begin
            rx_ie_rise = reg_wdata[`SLT_RX_IE_BIT] &&
                         !st_reg.rx_irq_enable;
            mdm_ie_rise = reg_wdata[`SLT_MDM_IE_BIT] &&
                          !st_reg.modem_irq_enable;
            st_next.rx_irq_enable = reg_wdata[`SLT_RX_IE_BIT];
            st_next.modem_irq_enable = reg_wdata[`SLT_MDM_IE_BIT];
        end
        if (reg_wr && (reg_addr == `SLT_OFS_RATE)) begin
            st_next.tx_div = reg_wdata[7:0];
            st_next.rx_div = reg_wdata[15:8];
        end
        if (reg_wr && (reg_addr == `SLT_OFS_IRQ_MASK)) begin
            st_next.mask = reg_wdata[2:0];
        end
        if (reg_wr && (reg_addr == `SLT_OFS_IRQ_STS)) begin
            st_next.sts = st_reg.sts & ~reg_wdata[2:0];
        end
        if (reg_rd && (reg_addr == `SLT_OFS_RX_BUF)) begin
            st_next.rx_char_complete = 1'b0;
        end
        if (reg_rd && (reg_addr == `SLT_OFS_RX_CS)) begin
            st_next.modem_chg = 1'b0;
        end

        // ************************************************************
        // transmitter: holding buffer feeding a shifter
        // ************************************************************
        unique case (st_reg.tx_state)
            SLT_TX_IDLE: begin
                if (st_reg.hold_full) begin
                    // shifter takes the character at once
                    st_next.tx_shift = {1'b1, st_reg.hold, 1'b0};
                    st_next.hold_full = 1'b0;
                    st_next.tx_bitn = 4'h0;
                    st_next.tx_sub = 4'h0;
                    st_next.tx_state = SLT_TX_SEND;
                end
            end
            SLT_TX_SEND: begin
                if (tx_tick) begin
                    st_next.tx_sub = st_reg.tx_sub + 4'h1;
                    if (st_reg.tx_sub == `SLT_SUB_LAST) begin
                        st_next.tx_shift = {1'b1, st_reg.tx_shift[9:1]};
                        st_next.tx_bitn = st_reg.tx_bitn + 4'h1;
                        if (st_reg.tx_bitn == `SLT_TX_BIT_LAST) begin
                            st_next.tx_state = SLT_TX_IDLE;
                        end
                    end
                end
            end
            default: begin
                st_next.tx_state = SLT_TX_IDLE;
            end
        endcase
        if (reg_wr && (reg_addr == `SLT_OFS_TX_BUF)) begin
            st_next.hold = reg_wdata[7:0];
            st_next.hold_full = 1'b1;
        end
        // ready is the complement of hold_full
        ev_tx = st_reg.hold_full && !st_next.hold_full;
        st_next.ser_out = !st_next.brk &&
                          ((st_next.tx_state != SLT_TX_SEND) ||
                           st_next.tx_shift[0]);

        // ************************************************************
        // receiver
        // ************************************************************
        rx_in = st_reg.loopback_test ? st_reg.ser_out
                                     : st_reg.rx_lvl;
        unique case (st_reg.rx_state)
            SLT_RX_IDLE: begin
                if (!rx_in) begin
                    st_next.rx_sub = 4'h0;
                    st_next.rx_state = SLT_RX_START;
                end
            end
            SLT_RX_START: begin
                if (rx_tick) begin
                    st_next.rx_sub = st_reg.rx_sub + 4'h1;
                    if (st_reg.rx_sub == `SLT_SUB_MID) begin
                        st_next.rx_sub = 4'h0;
                        st_next.rx_bitn = 4'h0;
                        st_next.rx_state = rx_in ? SLT_RX_IDLE
                                                 : SLT_RX_DATA;
                    end
                end
            end
            SLT_RX_DATA: begin
                if (rx_tick) begin
                    st_next.rx_sub = st_reg.rx_sub + 4'h1;
                    if (st_reg.rx_sub == `SLT_SUB_LAST) begin
                        st_next.rx_sh = {rx_in, st_reg.rx_sh[7:1]};
                        st_next.rx_bitn = st_reg.rx_bitn + 4'h1;
                        if (st_reg.rx_bitn == `SLT_RX_BIT_LAST) begin
                            st_next.rx_state = SLT_RX_STOP;
                        end
                    end
                end
            end
            SLT_RX_STOP: begin
                if (rx_tick) begin
                    st_next.rx_sub = st_reg.rx_sub + 4'h1;
                    if (st_reg.rx_sub == `SLT_SUB_LAST) begin
                        // middle of first stop bit
                        st_next.rx_buf = st_reg.rx_sh;
                        ev_rx = 1'b1;
                        st_next.rx_state = SLT_RX_IDLE;
                    end
                end
            end
            default: begin
                st_next.rx_state = SLT_RX_IDLE;
            end
        endcase
        // hardware sets win over read clears
        if (ev_rx) begin
            st_next.rx_char_complete = 1'b1;
        end
        if (ev_mdm) begin
            st_next.modem_chg = 1'b1;
        end

        // ************************************************************
        // vectored request channels
        // ************************************************************
        if (st_reg.bus_req && bus_grant) begin
            st_next.vec_valid = 1'b1;
            if (st_reg.rx_pend) begin
                st_next.vec = VECTOR_BASE;
                st_next.rx_pend = 1'b0;
            end else begin
                st_next.vec = VECTOR_BASE + `SLT_VECTOR_STEP;
                st_next.tx_pend = 1'b0;
            end
        end
        if (!st_next.tx_irq_enable) begin
            st_next.tx_pend = 1'b0;
        end
        if (!st_next.rx_irq_enable && !st_next.modem_irq_enable) begin
            st_next.rx_pend = 1'b0;
        end
        if ((ev_tx && st_next.tx_irq_enable) ||
            (tx_ie_rise && !st_next.hold_full)) begin
            st_next.tx_pend = 1'b1;
        end
        if ((ev_rx && st_next.rx_irq_enable) ||
            (rx_ie_rise && st_reg.rx_char_complete)) begin
            st_next.rx_pend = 1'b1;
        end
        if ((ev_mdm && st_next.modem_irq_enable) ||
            (mdm_ie_rise && st_reg.modem_chg)) begin
            st_next.rx_pend = 1'b1;
        end
        st_next.bus_req = st_next.rx_pend || st_next.tx_pend;

        // sticky status: set wins over write-one-to-clear
        st_next.sts[`SLT_EV_RX] = st_next.sts[`SLT_EV_RX] || ev_rx;
        st_next.sts[`SLT_EV_TX] = st_next.sts[`SLT_EV_TX] || ev_tx;
        st_next.sts[`SLT_EV_MDM] = st_next.sts[`SLT_EV_MDM] || ev_mdm;
        st_next.irq = |(st_next.sts & st_next.mask);

        // ************************************************************
        // read data, valid in the cycle after the strobe
        // ************************************************************
        if (reg_rd) begin
            unique case (reg_addr)
                `SLT_OFS_RX_CS: begin
                    rd_val[`SLT_MDM_CHG_BIT] = st_reg.modem_chg;
                    rd_val[`SLT_CARRIER_BIT] = st_reg.mdm[3];
                    rd_val[`SLT_CTS_BIT] = st_reg.mdm[2];
                    rd_val[`SLT_SEC_BIT] = st_reg.mdm[1];
                    rd_val[`SLT_RING_BIT] = st_reg.mdm[0];
                    rd_val[`SLT_RX_DONE_BIT] = st_reg.rx_char_complete;
                    rd_val[`SLT_RX_IE_BIT] = st_reg.rx_irq_enable;
                    rd_val[`SLT_MDM_IE_BIT] = st_reg.modem_irq_enable;
                end
                `SLT_OFS_RX_BUF: begin
                    rd_val[7:0] = st_reg.rx_buf;
                end
                `SLT_OFS_TX_CS: begin
                    rd_val[`SLT_TX_RDY_BIT] = !st_reg.hold_full;
                    rd_val[`SLT_TX_IE_BIT] = st_reg.tx_irq_enable;
                    rd_val[`SLT_LOOP_BIT] = st_reg.loopback_test;
                    rd_val[`SLT_BRK_BIT] = st_reg.brk;
                end
                `SLT_OFS_RATE: begin
                    rd_val = {st_reg.rx_div, st_reg.tx_div};
                end
                `SLT_OFS_IRQ_STS: begin
                    rd_val[2:0] = st_reg.sts;
                end
                `SLT_OFS_IRQ_MASK: begin
                    rd_val[2:0] = st_reg.mask;
                end
                default: begin
                    // holding buffer and unmapped offsets read zero
                    rd_val = 16'h0000;
                end
            endcase
        end
        st_next.rdata = rd_val;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.tx_state <= SLT_TX_IDLE;
            st_reg.rx_state <= SLT_RX_IDLE;
            st_reg.hold_full <= 1'b0;
            st_reg.ser_out <= 1'b1;
            st_reg.s1 <= 1'b1;
            st_reg.s2 <= 1'b1;
            st_reg.s3 <= 1'b1;
            st_reg.rx_lvl <= 1'b1;
            st_reg.tx_shift <= 10'h3FF;
            {st_reg.rx_div, st_reg.tx_div} <= `SLT_RATE_RST;
            st_reg.mask <= `SLT_IRQ_MASK_RST;
            st_reg.level <= REQUEST_LEVEL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign serial_out = st_reg.ser_out;
    assign bus_request = st_reg.bus_req;
    assign bus_request_level = st_reg.level;
    assign vector = st_reg.vec;
    assign vector_valid = st_reg.vec_valid;
    assign irq = st_reg.irq;

endmodule : slt_top

// *** verification/slt_top_checker.sv ***
`timescale 1ns/1ps
module slt_top_checker #(
    parameter logic [7:0] VECTOR_BASE = 8'h30,
    parameter logic [2:0] REQUEST_LEVEL = 3'h4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic serial_out,
    input wire logic bus_grant,
    input wire logic bus_request,
    input wire logic [2:0] bus_request_level,
    input wire logic [7:0] vector,
    input wire logic vector_valid
);
    // ********
    // port relations
    // ********
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence tx_load_s;
        reg_wr && reg_addr == 4'h6;
    endsequence
    sequence tx_cs_read_s;
        reg_rd && reg_addr == 4'h4;
    endsequence
    sequence granted_s;
        bus_grant && bus_request;
    endsequence
    level_fixed_a: assert property (
        bus_request_level == REQUEST_LEVEL)
        else $error("request level off its setting");
    ready_clears_a: assert property (
        tx_load_s ##1 tx_cs_read_s |=> !reg_rdata[7])
        else $error("ready still set after buffer load");
    tx_unused_a: assert property (
        tx_cs_read_s |=> (reg_rdata & 16'hFF3A) == 16'h0000)
        else $error("unused control bits read nonzero");
    ro_buffer_a: assert property (
        reg_rd && reg_addr == 4'h6 |=> reg_rdata == 16'h0000)
        else $error("holding buffer readable");
    grant_answer_a: assert property (
        granted_s |=> vector_valid &&
        (vector == VECTOR_BASE || vector == VECTOR_BASE + 8'h04))
        else $error("no proper vector after grant");
    no_grant_a: assert property (
        !(bus_grant && bus_request) |=> !vector_valid)
        else $error("vector without accepted grant");
    break_space_a: assert property (
        reg_wr && reg_addr == 4'h4 && reg_wdata[0] |=> ##1 !serial_out)
        else $error("break did not force space");
    req_drop_a: assert property (
        $fell(bus_request) |-> vector_valid || $past(reg_wr) ||
        $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("request withdrawn without grant");
endmodule : slt_top_checker

bind slt_top slt_top_checker #(.VECTOR_BASE(VECTOR_BASE),
    .REQUEST_LEVEL(REQUEST_LEVEL)) u_chk (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_out(serial_out),
    .bus_grant(bus_grant), .bus_request(bus_request),
    .bus_request_level(bus_request_level), .vector(vector),
    .vector_valid(vector_valid));

// *** verification/slt_remote.sv ***
`timescale 1ns/1ps
module slt_remote #(
    parameter int BIT_CYC = 16
) (
    input wire logic mclk,
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got [$];
    // ********
    // far terminal
    // ********
    initial line_out = 1'b1;
    task automatic send(input logic [7:0] ch, input int gap);
        logic [9:0] fr;
        fr = {1'b1, ch, 1'b0};
        repeat (gap) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            line_out <= fr[i];
            repeat (BIT_CYC) @(posedge mclk);
        end
    endtask : send
    // frames without a valid stop level are dropped
    initial begin
        logic [7:0] sh;
        forever begin
            @(negedge line_in);
            repeat (BIT_CYC / 2) @(posedge mclk);
            if (line_in === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge mclk);
                    sh[i] = line_in;
                end
                repeat (BIT_CYC) @(posedge mclk);
                if (line_in === 1'b1) got.push_back(sh);
            end
        end
    end
endmodule : slt_remote

// *** verification/slt_top_bench.sv ***
`timescale 1ns/1ps
module slt_top_bench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bus_grant = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] modem = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, v;
    logic serial_in, serial_out, bus_request, vector_valid, irq;
    logic [2:0] bus_request_level;
    logic [7:0] vector;
    int fails = 0;
    int n_compared = 0;
    always #5 mclk = ~mclk;
    slt_top uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .serial_in(serial_in),
        .serial_out(serial_out), .carrier_sense(modem[0]),
        .clear_to_send_in(modem[1]), .secondary_receive_in(modem[2]),
        .ring_indicate_in(modem[3]), .bus_grant(bus_grant),
        .bus_request(bus_request), .bus_request_level(bus_request_level),
        .vector(vector), .vector_valid(vector_valid), .irq(irq));
    slt_remote rem (.mclk(mclk), .line_in(serial_out), .line_out(serial_in));
    // ********
    // shared tasks
    // ********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic need(input logic ok);
        if (ok !== 1'b1) begin
            fails++;
            finish_test();
        end
    endtask : need
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        // a write that ended in this step still has its strobe going low
        if (reg_wr === 1'b1) @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        v = reg_rdata;
    endtask : rd
    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(posedge mclk);
        need(s);
    endtask : wait_hi
    task automatic grant(input logic [7:0] e);
        wait_hi(bus_request, 50);
        bus_grant <= 1'b1;
        @(posedge mclk);
        bus_grant <= 1'b0;
        @(posedge mclk);
        chk({7'h00, vector_valid, vector}, {8'h01, e});
    endtask : grant
    task automatic wait_rx;
        v = 16'h0000;
        for (int i = 0; i < 200 && v[7] !== 1'b1; i++) rd(4'h0);
        need(v[7]);
    endtask : wait_rx
    // ********
    // scenarios
    // ********
    task automatic t_reset;
        rd(4'h4);
        chk(v, 16'h0080);
        rd(4'h6);
        chk(v, 16'h0000);
        rd(4'hE);
        chk(v, 16'h0000);
        chk({13'h0000, bus_request_level}, 16'h0004);
    endtask : t_reset
    task automatic t_regs;
        wr(4'h4, 16'hFF39);
        rd(4'h4);
        chk(v, 16'h0081);
        chk({15'h0000, serial_out}, 16'h0000);
        wr(4'h4, 16'h0004);
        rd(4'h4);
        chk(v, 16'h0084);
        wr(4'h4, 16'h0000);
        repeat (3) @(posedge mclk);
        chk({15'h0000, serial_out}, 16'h0001);
    endtask : t_regs
    task automatic t_tx;
        wr(4'h6, 16'h7EA5);
        rd(4'h4);
        chk(v, 16'h0000);
        rd(4'h4);
        chk(v, 16'h0080);
        wr(4'h6, 16'h003C);
        rd(4'h4);
        chk(v, 16'h0000);
        repeat (100) @(posedge mclk);
        rd(4'h4);
        chk(v, 16'h0000);
        for (int i = 0; i < 400 && rem.got.size() < 2; i++) @(posedge mclk);
        need(rem.got.size() >= 2);
        chk({rem.got[0], rem.got[1]}, 16'hA53C);
        rd(4'h4);
        chk(v, 16'h0080);
    endtask : t_tx
    task automatic t_loop;
        wr(4'h8, 16'hFF00);
        rd(4'h8);
        chk(v, 16'hFF00);
        wr(4'h4, 16'h0004);
        wr(4'h6, 16'h0069);
        wait_rx();
        rd(4'h2);
        chk(v, 16'h0069);
        wr(4'h4, 16'h0000);
        wr(4'h8, 16'h0000);
    endtask : t_loop
    task automatic t_irq;
        wr(4'hA, 16'h0007);
        wr(4'hC, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
        wr(4'h6, 16'h0055);
        wait_hi(irq, 20);
        rd(4'hA);
        chk(v, 16'h0002);
        rd(4'hC);
        chk(v, 16'h0002);
        wr(4'hA, 16'h0002);
        repeat (3) @(posedge mclk);
        chk({15'h0000, irq}, 16'h0000);
    endtask : t_irq
    task automatic t_prio;
        repeat (200) @(posedge mclk);
        wr(4'h0, 16'h0040);
        wr(4'h4, 16'h0040);
        grant(8'h34);
        wr(4'h6, 16'h0011);
        rem.send(8'hC3, 2);
        wait_rx();
        grant(8'h30);
        grant(8'h34);
        wr(4'h4, 16'h0000);
        rd(4'h2);
        chk(v, 16'h00C3);
        wr(4'h0, 16'h0000);
    endtask : t_prio
    task automatic t_modem;
        rd(4'h0);
        for (int i = 0; i < 4; i++) begin
            modem[i] <= 1'b1;
            repeat (8) @(posedge mclk);
            rd(4'h0);
            chk({15'h0000, v[15]}, 16'h0001);
            rd(4'h0);
            chk({15'h0000, v[15]}, 16'h0000);
        end
        wr(4'h0, 16'h0020);
        modem[0] <= 1'b0;
        grant(8'h30);
        rd(4'hA);
        chk(v, 16'h0007);
    endtask : t_modem
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        wr(4'h8, 16'h0000);
        t_reset();
        t_regs();
        t_tx();
        t_loop();
        t_irq();
        t_prio();
        t_modem();
        finish_test();
    end
endmodule : slt_top_bench
